// *** pwr_wake_ctrl.sv ***
// Wake event status, wake pin, sleep timing and clock gating control.
`timescale 1ns/1ns
module pwr_wake_ctrl #(
	parameter int SLEEP_UNIT = pwr_pkg::SLEEP_UNIT_CYC,
	parameter int WAIT0      = pwr_pkg::WAIT0_CYC,
	parameter int WAIT1      = pwr_pkg::WAIT1_CYC,
	parameter int WAIT2      = pwr_pkg::WAIT2_CYC,
	parameter int WAIT3      = pwr_pkg::WAIT3_CYC
) (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst,
	// Host register port
	input  wire pwr_pkg::reg_req_t     i_req,
	output logic [15:0]                o_reg_rdata,
	output logic                       o_reg_rvalid,
	// Detector events and activity
	input  wire pwr_pkg::wake_events_t i_events,
	input  wire logic                  i_energy_present,
	input  wire logic [2:0]            i_mii_busy,
	input  wire logic                  i_host_active,
	// Power outputs
	output logic                       o_wake_event_pin,
	output logic [1:0]                 o_power_mode,
	output logic                       o_low_power,
	output logic                       o_switch_clk_en,
	output logic                       o_cpu_clk_en
);
	import pwr_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [3:0]         status_reg;
	logic [3:0]         status_next;
	logic [1:0]         mode_reg;
	logic [4:0]         enable_reg;
	logic [7:0]         go_sleep_reg;
	logic [4:0]         clk_ctrl_reg;
	logic [31:0]        tick_reg;
	logic [7:0]         sleep_cnt_reg;
	sleep_state_t       state_reg;
	sleep_state_t       state_next;
	logic               wr_status;
	logic               wr_enable;
	logic               wr_sleep;
	logic               wr_clk;
	logic [3:0]         w1c;
	logic [3:0]         ev_vec;
	logic               pin_active;
	logic               no_energy;
	logic               unit_done;
	logic [IDLE_W-1:0]  wait_limit;
	logic               mii_idle;
	logic               cpu_idle;

	assign wr_status = i_req.wr && i_req.addr == OFS_PM_STATUS;
	assign wr_enable = i_req.wr && i_req.addr == OFS_WAKE_ENABLE;
	assign wr_sleep  = i_req.wr && i_req.addr == OFS_GO_SLEEP;
	assign wr_clk    = i_req.wr && i_req.addr == OFS_CLK_SHUT;

	// ----------------------------------------------------------------
	// Wake event status
	// ----------------------------------------------------------------
	// Bit order follows the status register: frame, magic, link, energy.
	assign ev_vec = {i_events.wake_frame, i_events.magic,
		i_events.link_up, i_events.energy};
	assign w1c = wr_status ? i_req.wdata[ST_FRAME_BIT:ST_EVENT_LSB]
		: 4'h0;

	// A detection in the cycle of a clearing write is kept, never lost.
	assign status_next = (status_reg & ~w1c) | ev_vec;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			status_reg <= 4'h0;
		end else begin
			status_reg <= status_next;
		end
	end

	// ----------------------------------------------------------------
	// Power mode
	// ----------------------------------------------------------------
	// The clear pattern also clears the energy flag through its W1C bit.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_reg <= MODE_NORMAL;
		end else if (wr_status) begin
			if (i_req.wdata[ST_FRAME_BIT:ST_EVENT_LSB] == MODE_CLEAR_PAT)
			begin
				mode_reg <= MODE_NORMAL;
			end else begin
				mode_reg <= i_req.wdata[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			enable_reg <= 5'h00;
		end else if (wr_enable) begin
			enable_reg <= i_req.wdata[4:0];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			go_sleep_reg <= GO_SLEEP_RESET;
		end else if (wr_sleep) begin
			go_sleep_reg <= i_req.wdata[7:0];
		end
	end

	// Bit 4 is a spare read/write bit with no effect.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_ctrl_reg <= 5'h00;
		end else if (wr_clk) begin
			clk_ctrl_reg <= i_req.wdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	// Unmapped and reserved locations read as zero.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_req.rd) begin
			unique case (i_req.addr)
				OFS_PM_STATUS:
					o_reg_rdata <= {10'h000, status_reg, mode_reg};
				OFS_WAKE_ENABLE:
					o_reg_rdata <= {11'h000, enable_reg};
				OFS_GO_SLEEP:
					o_reg_rdata <= {8'h00, go_sleep_reg};
				OFS_CLK_SHUT:
					o_reg_rdata <= {11'h000, clk_ctrl_reg};
				default:
					o_reg_rdata <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_req.rd;
		end
	end

	// ----------------------------------------------------------------
	// Wake event pin
	// ----------------------------------------------------------------
	// Level output: it follows the sticky bits, so software deasserts it
	// by clearing the enabled flags or by clearing their enable bits.
	assign pin_active = |(status_reg & enable_reg[3:0]);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wake_event_pin <= 1'b1;
		end else if (enable_reg[EN_POL_BIT]) begin
			o_wake_event_pin <= pin_active;
		end else begin
			o_wake_event_pin <= ~pin_active;
		end
	end

	// ----------------------------------------------------------------
	// Go-sleep timing
	// ----------------------------------------------------------------
	assign no_energy = mode_reg == MODE_ENERGY && !i_energy_present;
	assign unit_done = tick_reg == 32'(SLEEP_UNIT - 1);

	// The unit tick restarts whenever energy returns, so the count only
	// grows over an unbroken no-energy spell.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			tick_reg <= 32'h00000000;
		end else if (!no_energy || unit_done) begin
			tick_reg <= 32'h00000000;
		end else begin
			tick_reg <= tick_reg + 32'h00000001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sleep_cnt_reg <= 8'h00;
		end else if (!no_energy) begin
			sleep_cnt_reg <= 8'h00;
		end else if (unit_done && sleep_cnt_reg != 8'hFF) begin
			sleep_cnt_reg <= sleep_cnt_reg + 8'h01;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_AWAKE: begin
				if (no_energy && sleep_cnt_reg >= go_sleep_reg) begin
					state_next = ST_ASLEEP;
				end
			end
			ST_ASLEEP: begin
				if (!no_energy) begin
					state_next = ST_AWAKE;
				end
			end
			default: state_next = ST_AWAKE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_AWAKE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Registered copy of the sleep state, so the output carries no decode.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_low_power <= 1'b0;
		end else begin
			o_low_power <= state_next == ST_ASLEEP;
		end
	end

	assign o_power_mode = mode_reg;

	// ----------------------------------------------------------------
	// Clock tree gating
	// ----------------------------------------------------------------
	always_comb begin
		unique case (clk_ctrl_reg[1:0])
			2'h0: wait_limit = IDLE_W'(WAIT0);
			2'h1: wait_limit = IDLE_W'(WAIT1);
			2'h2: wait_limit = IDLE_W'(WAIT2);
			2'h3: wait_limit = IDLE_W'(WAIT3);
		endcase
	end

	assign mii_idle = ~|i_mii_busy;
	assign cpu_idle = mii_idle && !i_host_active;

	pwr_idle_timer #(
		.W (IDLE_W)
	) u_switch_timer (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_enable  (clk_ctrl_reg[CS_SWITCH_BIT]),
		.i_idle    (mii_idle),
		.i_limit   (wait_limit),
		.o_clk_en  (o_switch_clk_en)
	);

	pwr_idle_timer #(
		.W (IDLE_W)
	) u_cpu_timer (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_enable  (clk_ctrl_reg[CS_CPU_BIT]),
		.i_idle    (cpu_idle),
		.i_limit   (wait_limit),
		.o_clk_en  (o_cpu_clk_en)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_frame_set_wins: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_events.wake_frame |=> status_reg[3])
		else $error("wake frame event lost");

	a_magic_sticky: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		status_reg[2] && !(wr_status && i_req.wdata[4]) |=> status_reg[2])
		else $error("magic flag dropped without clear");

	a_link_w1c: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		wr_status && i_req.wdata[3] && !i_events.link_up
			|=> !status_reg[1])
		else $error("link flag not cleared by write one");

	a_mode_clear: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		wr_status && i_req.wdata[5:2] == MODE_CLEAR_PAT
			|=> mode_reg == MODE_NORMAL)
		else $error("mode not cleared by clear pattern");

	a_pin_level: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		##1 o_wake_event_pin == ($past(enable_reg[EN_POL_BIT])
			~^ |($past(status_reg) & $past(enable_reg[3:0]))))
		else $error("wake pin level wrong");

	a_sleep_exit: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		o_low_power && i_energy_present |=> !o_low_power)
		else $error("did not wake on energy");

	a_sleep_only_energy: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		$rose(o_low_power) |-> $past(mode_reg) == MODE_ENERGY
			&& $past(sleep_cnt_reg) >= $past(go_sleep_reg))
		else $error("sleep entered early or outside energy mode");

	a_read_answer: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_req.rd && i_req.addr == OFS_PM_STATUS
			|=> o_reg_rvalid && o_reg_rdata[1:0] == $past(mode_reg))
		else $error("status read does not show mode");

	a_energy_sticky: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		status_reg[0] && !(wr_status && i_req.wdata[2]) |=> status_reg[0])
		else $error("energy flag dropped without clear");

	a_mode_write: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		wr_status && i_req.wdata[5:2] != MODE_CLEAR_PAT
			|=> mode_reg == $past(i_req.wdata[1:0]))
		else $error("mode field not loaded by write");

	a_go_sleep_load: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		wr_sleep |=> go_sleep_reg == $past(i_req.wdata[7:0]))
		else $error("go-sleep count not loaded by write");

	a_switch_always_on: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		!clk_ctrl_reg[CS_SWITCH_BIT] |=> o_switch_clk_en)
		else $error("switch clock gated while disabled");

	a_cpu_on_activity: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		i_host_active || |i_mii_busy |=> o_cpu_clk_en)
		else $error("cpu clock not restored after activity");

endmodule

// *** pwr_pkg.sv ***
// Package with register map, field layout and timing for power control.
// Overview of operation
// - Status bit 5 latches wake-up frame detection until written with one.
// - Status bit 4 latches magic packet detection until written with one.
// - Status bit 3 latches link-up detection until written with one.
// - Status bit 2 latches line energy detection until written with one.
// - Mode bits 1:0 select normal, energy detect, soft power-down.
// - Writing 0001 into status bits 5:2 clears the mode field.
// - Enable bit 4 picks wake pin polarity; zero means active low.
// - Enable bit 3 lets a wake-up frame assert the wake pin.
// - Enable bit 2 lets a magic packet assert the wake pin.
// - Enable bit 1 lets link-up assert the wake pin.
// - Enable bit 0 lets line energy assert the wake pin.
// - Energy mode sleeps after no energy for go-sleep count times 20 ms.
// - Clock-control bit 3 stops switch clock after MII idle period.
// - Switch clock restarts as soon as any MII becomes busy.
// - Clock-control bit 2 stops CPU clock after host and MII idle.
// - Wait field 1:0 selects 5.3 s, 1.6 s, 1 ms or 3.2 us.
package pwr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_PM_STATUS   = 8'h32;
	localparam logic [7:0]  OFS_WAKE_ENABLE = 8'h34;
	localparam logic [7:0]  OFS_GO_SLEEP    = 8'h36;
	localparam logic [7:0]  OFS_CLK_SHUT    = 8'h38;
	localparam logic [3:0]  MODE_CLEAR_PAT  = 4'h1;
	localparam logic [7:0]  GO_SLEEP_RESET  = 8'h8E;
	localparam int          ST_FRAME_BIT    = 5;
	localparam int          ST_EVENT_LSB    = 2;
	localparam int          EN_POL_BIT      = 4;
	localparam int          CS_SWITCH_BIT   = 3;
	localparam int          CS_CPU_BIT      = 2;
	localparam logic [1:0]  MODE_NORMAL     = 2'h0;
	localparam logic [1:0]  MODE_ENERGY     = 2'h1;
	localparam logic [1:0]  MODE_SOFT_DOWN  = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int SLEEP_UNIT_MS  = 20;
	localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * 1000 * CLK_MHZ;
	localparam int WAIT0_US       = 5300000;
	localparam int WAIT1_US       = 1600000;
	localparam int WAIT2_US       = 1000;
	localparam int WAIT3_NS       = 3200;
	localparam int WAIT0_CYC      = WAIT0_US * CLK_MHZ;
	localparam int WAIT1_CYC      = WAIT1_US * CLK_MHZ;
	localparam int WAIT2_CYC      = WAIT2_US * CLK_MHZ;
	localparam int WAIT3_CYC      = WAIT3_NS * CLK_MHZ / 1000;
	localparam int IDLE_W         = 30;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wake_frame;
		logic magic;
		logic link_up;
		logic energy;
	} wake_events_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		ST_AWAKE  = 2'b01,
		ST_ASLEEP = 2'b10
	} sleep_state_t;

endpackage

// *** pwr_idle_timer.sv ***
// Idle timer that gates one clock after a programmable idle period.
`timescale 1ns/1ns
module pwr_idle_timer #(
	parameter int W = 30
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	// Control
	input  wire logic         i_enable,
	input  wire logic         i_idle,
	input  wire logic [W-1:0] i_limit,
	// Gate
	output logic              o_clk_en
);

	logic [W-1:0] cnt_reg;

	// ----------------------------------------------------------------
	// Idle counter
	// ----------------------------------------------------------------
	// Saturates at the limit so a long idle spell never wraps round.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_reg <= '0;
		end else if (!i_enable || !i_idle) begin
			cnt_reg <= '0;
		end else if (cnt_reg < i_limit) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Gate drops only after more idle cycles than the limit.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_clk_en <= 1'b1;
		end else if (!i_enable || !i_idle) begin
			o_clk_en <= 1'b1;
		end else if (cnt_reg == i_limit) begin
			o_clk_en <= 1'b0;
		end
	end

	a_wake_on_busy: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		!i_idle |=> o_clk_en)
		else $error("clock not restored after activity");

	a_gate_after_limit: assert property (
		@(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_clk_en) |-> $past(i_enable) && $past(i_idle)
			&& $past(cnt_reg) == $past(i_limit))
		else $error("clock gated before idle limit");

endmodule

// *** host_wake_mon.sv ***
// Host model that watches the wake pin at the programmed polarity.
`timescale 1ns/1ns
module host_wake_mon (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// Pin and expected polarity
	input  wire logic i_wake_pin,
	input  wire logic i_pol,
	// Host view
	output logic      o_woken
);
	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	// The host only trusts a registered sample, as a real host would.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_woken <= 1'b0;
		end else begin
			o_woken <= (i_wake_pin == i_pol);
		end
	end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the wake and power control block.
`timescale 1ns/1ns
module tb_top;
	import pwr_pkg::*;
	localparam int SU = 10;
	localparam int WT[4] = '{40, 30, 20, 10};
	logic         i_sys_clk = 1'b0;
	logic         i_rst = 1'b1;
	reg_req_t     i_req = '0;
	wake_events_t i_events = '0;
	logic         i_energy_present = 1'b1;
	logic         i_host_active = 1'b1;
	logic [2:0]   i_mii_busy = 3'h7;
	logic [15:0]  o_reg_rdata;
	logic         o_reg_rvalid;
	logic         o_wake_event_pin;
	logic [1:0]   o_power_mode;
	logic         o_low_power;
	logic         o_switch_clk_en;
	logic         o_cpu_clk_en;
	logic         pol = 1'b0;
	logic         host_woken;
	int           failures = 0;
	int           tests_run = 0;
	logic [15:0]  exp_q[$];

	pwr_wake_ctrl #(.SLEEP_UNIT(SU), .WAIT0(WT[0]), .WAIT1(WT[1]),
		.WAIT2(WT[2]), .WAIT3(WT[3])) i_pwr_wake_ctrl (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.i_events(i_events), .i_energy_present(i_energy_present),
		.i_mii_busy(i_mii_busy), .i_host_active(i_host_active),
		.o_wake_event_pin(o_wake_event_pin), .o_power_mode(o_power_mode),
		.o_low_power(o_low_power), .o_switch_clk_en(o_switch_clk_en),
		.o_cpu_clk_en(o_cpu_clk_en));
	host_wake_mon i_host_wake_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_wake_pin(o_wake_event_pin), .i_pol(pol), .o_woken(host_woken));

	// ----------------------------------------------------------------
	// Clock, comparison and verdict
	// ----------------------------------------------------------------
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cmp_pin(input logic exp, input string what);
		cmp(16'(o_wake_event_pin), 16'(exp), what);
	endtask
	// Read data is matched against the oldest note left by the driver.
	// Sampled on the falling edge, where the registered answer is settled.
	always @(negedge i_sys_clk) begin
		if (o_reg_rvalid === 1'b1) begin
			if (exp_q.size() > 0) begin
				cmp(o_reg_rdata, exp_q.pop_front(), "read");
			end else begin
				cmp(1'b1, 1'b0, "unexpected read data");
			end
		end
	end
	initial begin
		#400000;
		failures++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic ticks(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_req.addr <= a;
		i_req.wdata <= d;
		i_req.wr <= 1'b1;
		@(posedge i_sys_clk);
		i_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_req.addr <= a;
		i_req.rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge i_sys_clk);
		i_req.rd <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge i_sys_clk);
		i_events <= wake_events_t'(m);
		@(posedge i_sys_clk);
		i_events <= '0;
		ticks(2);
	endtask
	// Holds the gated side busy, programs the control word, then idles
	// and measures how long the clock keeps running.
	task automatic gate(input logic [15:0] ctrl, input int lim,
		input logic cpu);
		int          n;
		logic [15:0] ok;
		n = 0;
		@(posedge i_sys_clk);
		i_mii_busy <= 3'h7;
		i_host_active <= 1'b1;
		wr(OFS_CLK_SHUT, ctrl);
		@(posedge i_sys_clk);
		i_mii_busy <= 3'h0;
		i_host_active <= ~cpu;
		#1;
		while ((cpu ? o_cpu_clk_en : o_switch_clk_en) === 1'b1 && n < 200)
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		ok = 16'(n >= lim + 1 && n <= lim + 3);
		cmp(ok, 16'h1, "gate time");
		ok = 16'(cpu ? o_switch_clk_en : o_cpu_clk_en);
		cmp(ok, 16'h1, "other");
		@(posedge i_sys_clk);
		if (cpu) begin
			i_host_active <= 1'b1;
		end else begin
			i_mii_busy <= 3'h4;
		end
		ticks(2);
		ok = 16'(cpu ? o_cpu_clk_en : o_switch_clk_en);
		cmp(ok, 16'h1, "wake");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [3:0]  m;
		logic [3:0]  o;
		int          n;
		void'($urandom(42606));
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(OFS_PM_STATUS, 16'h0000);
		rd(OFS_WAKE_ENABLE, 16'h0000);
		rd(OFS_GO_SLEEP, 16'h008E);
		rd(OFS_CLK_SHUT, 16'h0000);
		rd(8'h3A, 16'h0000);
		d = 16'($urandom);
		wr(OFS_WAKE_ENABLE, d);
		rd(OFS_WAKE_ENABLE, d & 16'h001F);
		for (int i = 0; i < 4; i++) begin
			m = 4'h1 << i;
			o = 4'h1 << ((i + 1) % 4);
			pol = 1'($urandom);
			wr(OFS_WAKE_ENABLE, {11'h0, pol, m});
			pulse(o);
			cmp_pin(!pol, "idle");
			pulse(m);
			cmp_pin(pol, "on");
			cmp(16'(host_woken), 16'h1, "host");
			d = {10'h0, m | o, 2'h0};
			rd(OFS_PM_STATUS, d);
			wr(OFS_PM_STATUS, {10'h0, m, 2'h0});
			d = {10'h0, o, 2'h0};
			rd(OFS_PM_STATUS, d);
			ticks(1);
			cmp_pin(!pol, "off");
			wr(OFS_PM_STATUS, d);
			rd(OFS_PM_STATUS, 16'h0000);
		end
		wr(OFS_PM_STATUS, {14'h0, MODE_SOFT_DOWN});
		rd(OFS_PM_STATUS, 16'h0002);
		wr(OFS_PM_STATUS, 16'h0004);
		rd(OFS_PM_STATUS, 16'h0000);
		wr(OFS_GO_SLEEP, 16'h0002);
		wr(OFS_PM_STATUS, {14'h0, MODE_ENERGY});
		@(posedge i_sys_clk);
		i_energy_present <= 1'b0;
		n = 0;
		#1;
		while (o_low_power !== 1'b1 && n < 200) begin
			ticks(1);
			n++;
		end
		d = 16'(n >= 2 * SU && n <= 3 * SU + 3);
		cmp(d, 16'h1, "sleep time");
		cmp(16'(o_power_mode), 16'h1, "mode");
		@(posedge i_sys_clk);
		i_energy_present <= 1'b1;
		ticks(2);
		cmp(16'(o_low_power), 16'h0, "awake");
		wr(OFS_PM_STATUS, 16'h0004);
		ticks(2);
		cmp(16'(o_power_mode), 16'h0, "mode clear");
		for (int c = 0; c < 4; c++) begin
			gate(16'h0008 | 16'(c), WT[c], 1'b0);
		end
		gate(16'h0006, WT[2], 1'b1);
		ticks(4);
		cmp(16'(exp_q.size()), 16'h0, "queue");
		print_verdict();
	end
endmodule
